// *** hw/ccr_top.sv ***
// Purpose: Clock/reference control and status register bank, AXI4-Lite slave
// Assumes: One clock REF_CLK, synchronous active-low RST_B
// Notes:   Edge position status arrives from the capture logic asynchronously
`timescale 1ns/100ps
module ccr_top (
	input  wire logic        REF_CLK,
	input  wire logic        RST_B,
	input  wire logic [9:0]  S_AXI_AWADDR,
	input  wire logic        S_AXI_AWVALID,
	output logic             S_AXI_AWREADY,
	input  wire logic [31:0] S_AXI_WDATA,
	input  wire logic [3:0]  S_AXI_WSTRB,
	input  wire logic        S_AXI_WVALID,
	output logic             S_AXI_WREADY,
	output logic [1:0]       S_AXI_BRESP,
	output logic             S_AXI_BVALID,
	input  wire logic        S_AXI_BREADY,
	input  wire logic [9:0]  S_AXI_ARADDR,
	input  wire logic        S_AXI_ARVALID,
	output logic             S_AXI_ARREADY,
	output logic [31:0]      S_AXI_RDATA,
	output logic [1:0]       S_AXI_RRESP,
	output logic             S_AXI_RVALID,
	input  wire logic        S_AXI_RREADY,
	input  wire logic [23:0] EDGE_POSITION_IN,
	input  wire logic        TIMESTAMP_OUTPUT_ENABLE,
	input  wire logic        SYSREF_IN,
	input  wire logic        SAMPLE_LSB_IN,
	output logic [3:0]       SYSREF_DELAY_SELECT,
	output logic             SYSREF_WINDOW_ZOOM,
	output logic             SYSREF_ALIGN,
	output logic             SAMPLE_LSB_OUT,
	output logic             DEVICE_CLOCK_DC_COUPLED_ENABLE,
	output logic             SYSREF_DC_COUPLED_ENABLE,
	output logic [15:0]      INPUT_A_FULLSCALE_CODE,
	output logic [15:0]      INPUT_B_FULLSCALE_CODE,
	output logic             INPUT_A_FULLSCALE_LOW,
	output logic             INPUT_B_FULLSCALE_LOW,
	output logic             REFERENCE_BYPASS,
	output logic             TIMESTAMP_RECEIVER_ENABLE,
	output logic             TIMESTAMP_DC_COUPLED_ENABLE
);

	typedef struct packed {
		ccr_pkg::ccr_regs_t regs;
		ccr_pkg::ccr_bus_t  bus;
		logic [23:0]        pos_s1;
		logic [23:0]        pos_s2;
		logic [23:0]        pos_s3;
		logic [23:0]        pos_held;
		logic [2:0]         ref_s1;
		logic [2:0]         ref_s2;
		logic               align;
		logic               lsb;
		logic               aw_rdy;
		logic               w_rdy;
		logic               ar_rdy;
		logic               fs_a_low;
		logic               fs_b_low;
	} ccr_state_t;

	ccr_state_t st_r;
	ccr_state_t st_nxt;

	// True for indices that hold a register; others answer SLVERR
	function automatic logic idx_mapped(input logic [7:0] idx);
		case (idx)
			ccr_pkg::IDX_CLK_CTRL0, ccr_pkg::IDX_CLK_INPUT,
			ccr_pkg::IDX_POS_0, ccr_pkg::IDX_POS_1, ccr_pkg::IDX_POS_2,
			ccr_pkg::IDX_FS_A_LO, ccr_pkg::IDX_FS_A_HI,
			ccr_pkg::IDX_FS_B_LO, ccr_pkg::IDX_FS_B_HI,
			ccr_pkg::IDX_REF_SRC, ccr_pkg::IDX_TS_CTRL: idx_mapped = 1'b1;
			default: idx_mapped = 1'b0;
		endcase
	endfunction

	// Status bytes are not writable
	function automatic logic idx_status(input logic [7:0] idx);
		idx_status = (idx == ccr_pkg::IDX_POS_0) || (idx == ccr_pkg::IDX_POS_1) ||
			(idx == ccr_pkg::IDX_POS_2);
	endfunction

	logic       do_write;
	logic [7:0] wr_idx;
	logic [7:0] wr_byte;
	logic [7:0] rd_idx;
	logic [7:0] rd_byte;

	always_comb begin
		st_nxt = st_r;
		wr_idx = st_r.bus.aw_idx;
		wr_byte = st_r.bus.w_data[7:0];
		rd_idx = S_AXI_ARADDR[9:2];
		rd_byte = 8'h00;

		// Synchronisers: first stage feeds only the second
		st_nxt.pos_s1 = EDGE_POSITION_IN;
		st_nxt.pos_s2 = st_r.pos_s1;
		// Word kept only once two samples agree; bits may skew across the crossing
		st_nxt.pos_s3 = st_r.pos_s2;
		if (st_r.pos_s2 == st_r.pos_s3) begin
			st_nxt.pos_held = st_r.pos_s2;
		end
		st_nxt.ref_s1 = {SAMPLE_LSB_IN, TIMESTAMP_OUTPUT_ENABLE, SYSREF_IN};
		st_nxt.ref_s2 = st_r.ref_s1;

		// Address and data taken in either order
		if (S_AXI_AWVALID && !st_r.bus.aw_hold) begin
			st_nxt.bus.aw_hold = 1'b1;
			st_nxt.bus.aw_idx = S_AXI_AWADDR[9:2];
		end
		if (S_AXI_WVALID && !st_r.bus.w_hold) begin
			st_nxt.bus.w_hold = 1'b1;
			st_nxt.bus.w_data = S_AXI_WDATA;
			st_nxt.bus.w_strb = S_AXI_WSTRB;
		end

		do_write = st_r.bus.aw_hold && st_r.bus.w_hold && !st_r.bus.bvalid;
		if (do_write) begin
			st_nxt.bus.aw_hold = 1'b0;
			st_nxt.bus.w_hold = 1'b0;
			st_nxt.bus.bvalid = 1'b1;
			st_nxt.bus.bresp = ccr_pkg::RESP_OK;
			if (!idx_mapped(wr_idx) || idx_status(wr_idx)) begin
				st_nxt.bus.bresp = ccr_pkg::RESP_ERR;
			end else if (st_r.bus.w_strb[0]) begin
				// Full bytes stored; reserved bits read back, drive nothing
				case (wr_idx)
					ccr_pkg::IDX_CLK_CTRL0: st_nxt.regs.clk_ctrl0 = wr_byte;
					ccr_pkg::IDX_CLK_INPUT: st_nxt.regs.clk_input = wr_byte;
					ccr_pkg::IDX_FS_A_LO:   st_nxt.regs.fs_a[7:0] = wr_byte;
					ccr_pkg::IDX_FS_A_HI:   st_nxt.regs.fs_a[15:8] = wr_byte;
					ccr_pkg::IDX_FS_B_LO:   st_nxt.regs.fs_b[7:0] = wr_byte;
					ccr_pkg::IDX_FS_B_HI:   st_nxt.regs.fs_b[15:8] = wr_byte;
					ccr_pkg::IDX_REF_SRC:   st_nxt.regs.ref_src = wr_byte;
					ccr_pkg::IDX_TS_CTRL:   st_nxt.regs.ts_ctrl = wr_byte;
					default: st_nxt.regs = st_r.regs;
				endcase
			end
		end
		if (st_r.bus.bvalid && S_AXI_BREADY) begin
			st_nxt.bus.bvalid = 1'b0;
		end

		// Read: taken when idle, answered next cycle
		case (rd_idx)
			ccr_pkg::IDX_CLK_CTRL0: rd_byte = st_r.regs.clk_ctrl0;
			ccr_pkg::IDX_CLK_INPUT: rd_byte = st_r.regs.clk_input;
			ccr_pkg::IDX_POS_0:     rd_byte = st_r.pos_held[7:0];
			ccr_pkg::IDX_POS_1:     rd_byte = st_r.pos_held[15:8];
			ccr_pkg::IDX_POS_2:     rd_byte = st_r.pos_held[23:16];
			ccr_pkg::IDX_FS_A_LO:   rd_byte = st_r.regs.fs_a[7:0];
			ccr_pkg::IDX_FS_A_HI:   rd_byte = st_r.regs.fs_a[15:8];
			ccr_pkg::IDX_FS_B_LO:   rd_byte = st_r.regs.fs_b[7:0];
			ccr_pkg::IDX_FS_B_HI:   rd_byte = st_r.regs.fs_b[15:8];
			ccr_pkg::IDX_REF_SRC:   rd_byte = st_r.regs.ref_src;
			ccr_pkg::IDX_TS_CTRL:   rd_byte = st_r.regs.ts_ctrl;
			default:                rd_byte = 8'h00;
		endcase
		if (S_AXI_ARVALID && !st_r.bus.rvalid) begin
			st_nxt.bus.rvalid = 1'b1;
			st_nxt.bus.rdata = {24'h000000, rd_byte};
			st_nxt.bus.rresp = idx_mapped(rd_idx) ? ccr_pkg::RESP_OK : ccr_pkg::RESP_ERR;
		end else if (st_r.bus.rvalid && S_AXI_RREADY) begin
			st_nxt.bus.rvalid = 1'b0;
		end

		// Polarity applied to the alignment reference
		st_nxt.align = st_r.ref_s2[0] ^ st_r.regs.clk_input[ccr_pkg::INV_BIT];
		// Reference replaces the sample LSB only with both enables
		st_nxt.lsb = (st_r.regs.clk_input[ccr_pkg::SRTS_BIT] && st_r.ref_s2[1])
			? st_r.ref_s2[0] : st_r.ref_s2[2];

		if (!RST_B) begin
			st_nxt = '0;
			st_nxt.regs.clk_ctrl0 = ccr_pkg::RST_BYTE;
			st_nxt.regs.clk_input = ccr_pkg::RST_BYTE;
			st_nxt.regs.fs_a = ccr_pkg::RST_FS;
			st_nxt.regs.fs_b = ccr_pkg::RST_FS;
			st_nxt.regs.ref_src = ccr_pkg::RST_BYTE;
			st_nxt.regs.ts_ctrl = ccr_pkg::RST_BYTE;
		end

		// Derived outputs registered so every port leaves a flop
		st_nxt.aw_rdy = !st_nxt.bus.aw_hold;
		st_nxt.w_rdy = !st_nxt.bus.w_hold;
		st_nxt.ar_rdy = !st_nxt.bus.rvalid;
		// Flag only; low codes still apply, merely degraded
		st_nxt.fs_a_low = st_nxt.regs.fs_a < ccr_pkg::FS_MIN;
		st_nxt.fs_b_low = st_nxt.regs.fs_b < ccr_pkg::FS_MIN;
	end

	always_ff @(posedge REF_CLK) begin
		st_r <= st_nxt;
	end

	// Control outputs all come straight from state flops
	always_comb begin
		S_AXI_AWREADY = st_r.aw_rdy;
		S_AXI_WREADY = st_r.w_rdy;
		S_AXI_BVALID = st_r.bus.bvalid;
		S_AXI_BRESP = st_r.bus.bresp;
		S_AXI_ARREADY = st_r.ar_rdy;
		S_AXI_RVALID = st_r.bus.rvalid;
		S_AXI_RDATA = st_r.bus.rdata;
		S_AXI_RRESP = st_r.bus.rresp;
		SYSREF_DELAY_SELECT = st_r.regs.clk_ctrl0[ccr_pkg::DSEL_LSB +: 4];
		SYSREF_WINDOW_ZOOM = st_r.regs.clk_ctrl0[ccr_pkg::ZOOM_BIT];
		SYSREF_ALIGN = st_r.align;
		SAMPLE_LSB_OUT = st_r.lsb;
		DEVICE_CLOCK_DC_COUPLED_ENABLE = st_r.regs.clk_input[ccr_pkg::DCDC_BIT];
		SYSREF_DC_COUPLED_ENABLE = st_r.regs.clk_input[ccr_pkg::SRDC_BIT];
		INPUT_A_FULLSCALE_CODE = st_r.regs.fs_a;
		INPUT_B_FULLSCALE_CODE = st_r.regs.fs_b;
		INPUT_A_FULLSCALE_LOW = st_r.fs_a_low;
		INPUT_B_FULLSCALE_LOW = st_r.fs_b_low;
		REFERENCE_BYPASS = st_r.regs.ref_src[ccr_pkg::BYP_BIT];
		TIMESTAMP_RECEIVER_ENABLE = st_r.regs.ts_ctrl[ccr_pkg::TSRX_BIT];
		TIMESTAMP_DC_COUPLED_ENABLE = st_r.regs.ts_ctrl[ccr_pkg::TSDC_BIT];
	end

endmodule

// *** hw/ccr_pkg.sv ***
// Purpose: Shared constants and carriers for the clock/reference control bank
// Assumes: AXI4-Lite slave, 32-bit data, byte-address map
// Notes:   Printed offsets are not all multiples of four, so they are indices
package ccr_pkg;

	// Register indices; byte address is four times the index
	localparam logic [7:0] IDX_CLK_CTRL0   = 8'h29;
	localparam logic [7:0] IDX_CLK_INPUT   = 8'h2A;
	localparam logic [7:0] IDX_POS_0       = 8'h2C;
	localparam logic [7:0] IDX_POS_1       = 8'h2D;
	localparam logic [7:0] IDX_POS_2       = 8'h2E;
	localparam logic [7:0] IDX_FS_A_LO     = 8'h30;
	localparam logic [7:0] IDX_FS_A_HI     = 8'h31;
	localparam logic [7:0] IDX_FS_B_LO     = 8'h32;
	localparam logic [7:0] IDX_FS_B_HI     = 8'h33;
	localparam logic [7:0] IDX_REF_SRC     = 8'h38;
	localparam logic [7:0] IDX_TS_CTRL     = 8'h3B;

	// Field positions
	localparam int DSEL_LSB    = 0;
	localparam int ZOOM_BIT    = 4;
	localparam int INV_BIT     = 0;
	localparam int SRDC_BIT    = 1;
	localparam int DCDC_BIT    = 2;
	localparam int SRTS_BIT    = 3;
	localparam int BYP_BIT     = 0;
	localparam int TSRX_BIT    = 0;
	localparam int TSDC_BIT    = 1;

	// Reset values, low-code threshold and response codes
	localparam logic [7:0]  RST_BYTE = 8'h00;
	localparam logic [15:0] RST_FS   = 16'hA000;
	localparam logic [15:0] FS_MIN   = 16'h2000;
	localparam logic [1:0]  RESP_OK  = 2'h0;
	localparam logic [1:0]  RESP_ERR = 2'h2;

	typedef struct packed {
		logic [7:0]  clk_ctrl0;
		logic [7:0]  clk_input;
		logic [15:0] fs_a;
		logic [15:0] fs_b;
		logic [7:0]  ref_src;
		logic [7:0]  ts_ctrl;
	} ccr_regs_t;

	typedef struct packed {
		logic        aw_hold;
		logic [7:0]  aw_idx;
		logic        w_hold;
		logic [31:0] w_data;
		logic [3:0]  w_strb;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
	} ccr_bus_t;

endpackage

// *** tb/ccr_top_properties.sv ***
// Purpose: Port assertions for the control bank
// Assumes: Write address and data offered together
// Notes:   Outputs follow a write two edges later
`timescale 1ns/100ps
module ccr_top_properties (
	input wire logic	REF_CLK,
	input wire logic	RST_B,
	input wire logic [9:0]	S_AXI_AWADDR,
	input wire logic	S_AXI_AWVALID,
	input wire logic	S_AXI_AWREADY,
	input wire logic [31:0]	S_AXI_WDATA,
	input wire logic [3:0]	S_AXI_WSTRB,
	input wire logic	S_AXI_WVALID,
	input wire logic	S_AXI_WREADY,
	input wire logic [3:0]	SYSREF_DELAY_SELECT,
	input wire logic	SYSREF_WINDOW_ZOOM,
	input wire logic	DEVICE_CLOCK_DC_COUPLED_ENABLE,
	input wire logic	SYSREF_DC_COUPLED_ENABLE,
	input wire logic [15:0]	INPUT_A_FULLSCALE_CODE,
	input wire logic [15:0]	INPUT_B_FULLSCALE_CODE,
	input wire logic	INPUT_A_FULLSCALE_LOW,
	input wire logic	INPUT_B_FULLSCALE_LOW,
	input wire logic	REFERENCE_BYPASS,
	input wire logic	TIMESTAMP_RECEIVER_ENABLE,
	input wire logic	TIMESTAMP_DC_COUPLED_ENABLE
);
	default clocking @(posedge REF_CLK); endclocking
	default disable iff (!RST_B);
	wire logic	wr = S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY
		&& S_AXI_WSTRB[0];
	wire logic [7:0]	ix = S_AXI_AWADDR[9:2];
	chk_ctrl0_write: assert property (wr && ix == 8'h29 |-> ##2
		{SYSREF_WINDOW_ZOOM, SYSREF_DELAY_SELECT} == $past(S_AXI_WDATA[4:0], 2))
		else $error("ctrl0 load");
	chk_ctrl0_hold: assert property (!(wr && ix == 8'h29) |-> ##2
		$stable(SYSREF_DELAY_SELECT)) else $error("ctrl0 moved");
	chk_dc_write: assert property (wr && ix == 8'h2A |-> ##2
		{DEVICE_CLOCK_DC_COUPLED_ENABLE, SYSREF_DC_COUPLED_ENABLE} == $past(S_AXI_WDATA[2:1], 2))
		else $error("dc load");
	chk_ts_write: assert property (wr && ix == 8'h3B |-> ##2
		{TIMESTAMP_DC_COUPLED_ENABLE, TIMESTAMP_RECEIVER_ENABLE} == $past(S_AXI_WDATA[1:0], 2))
		else $error("ts load");
	chk_bypass_write: assert property (wr && ix == 8'h38 |-> ##2
		REFERENCE_BYPASS == $past(S_AXI_WDATA[0], 2)) else $error("bypass load");
	chk_low_a: assert property ($stable(INPUT_A_FULLSCALE_CODE) |->
		INPUT_A_FULLSCALE_LOW == (INPUT_A_FULLSCALE_CODE < ccr_pkg::FS_MIN)) else $error("low a");
	chk_low_b: assert property ($stable(INPUT_B_FULLSCALE_CODE) |->
		INPUT_B_FULLSCALE_LOW == (INPUT_B_FULLSCALE_CODE < ccr_pkg::FS_MIN)) else $error("low b");
	chk_fs_reset: assert property ($rose(RST_B) |->
		{INPUT_A_FULLSCALE_CODE, INPUT_B_FULLSCALE_CODE} == {2{ccr_pkg::RST_FS}})
		else $error("fs reset");
endmodule

// *** tb/ccr_top_tb.sv ***
// Purpose: Self-checking bench for the control bank
// Assumes: One transfer at a time
// Notes:   Rows first, then paths and reset by hand
`timescale 1ns/100ps
bind ccr_top ccr_top_properties ccr_top_properties_inst (.*);
module ccr_top_tb;
	typedef struct packed {
		logic [7:0] i;
		logic [7:0] w;
		logic [1:0] b;
		logic [7:0] r;
		logic [1:0] q;
	} ccr_row_t;
	localparam logic [1:0] OK = 2'h0;
	localparam logic [1:0] ER = 2'h2;
	logic	REF_CLK = 1'h0, RST_B = 1'h0, S_AXI_AWVALID = 1'h0, S_AXI_WVALID = 1'h0;
	logic	S_AXI_BREADY = 1'h0, S_AXI_ARVALID = 1'h0, S_AXI_RREADY = 1'h0;
	logic	TIMESTAMP_OUTPUT_ENABLE = 1'h0, SYSREF_IN = 1'h0, SAMPLE_LSB_IN = 1'h0;
	logic [9:0]	S_AXI_AWADDR = 10'h0, S_AXI_ARADDR = 10'h0;
	logic [3:0]	S_AXI_WSTRB = 4'h0, SYSREF_DELAY_SELECT;
	logic [31:0]	S_AXI_WDATA = 32'h0, S_AXI_RDATA;
	logic [23:0]	EDGE_POSITION_IN = 24'hC3B2A1;
	logic [1:0]	S_AXI_BRESP, S_AXI_RRESP;
	logic [15:0]	INPUT_A_FULLSCALE_CODE, INPUT_B_FULLSCALE_CODE;
	logic	S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARREADY, S_AXI_RVALID;
	logic	SYSREF_WINDOW_ZOOM, SYSREF_ALIGN, SAMPLE_LSB_OUT, REFERENCE_BYPASS;
	logic	DEVICE_CLOCK_DC_COUPLED_ENABLE, SYSREF_DC_COUPLED_ENABLE;
	logic	INPUT_A_FULLSCALE_LOW, INPUT_B_FULLSCALE_LOW;
	logic	TIMESTAMP_RECEIVER_ENABLE, TIMESTAMP_DC_COUPLED_ENABLE;
	int	failures = 0;
	int	compares = 0;
	ccr_row_t	rows [12] = '{
		'{8'h29, 8'h95, OK, 8'h95, OK},
		'{8'h2A, 8'hAF, OK, 8'hAF, OK},
		'{8'h30, 8'h34, OK, 8'h34, OK},
		'{8'h31, 8'h12, OK, 8'h12, OK},
		'{8'h32, 8'hFF, OK, 8'hFF, OK},
		'{8'h33, 8'hFF, OK, 8'hFF, OK},
		'{8'h38, 8'hFF, OK, 8'hFF, OK},
		'{8'h3B, 8'hFF, OK, 8'hFF, OK},
		'{8'h2C, 8'h00, ER, 8'hA1, OK},
		'{8'h2D, 8'h00, ER, 8'hB2, OK},
		'{8'h2E, 8'h00, ER, 8'hC3, OK},
		'{8'h10, 8'h55, ER, 8'h00, ER}
	};
	ccr_top ccr_top_inst (.*);
	always #20 REF_CLK = ~REF_CLK;
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		compares++;
		if (g !== e) begin
			failures++;
			$display("CHECK FAILED %0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic wr(input logic [7:0] i, d, input logic [3:0] s, input logic [1:0] r);
		@(posedge REF_CLK);
		S_AXI_AWADDR <= {i, 2'h0};
		S_AXI_WDATA <= {24'h0, d};
		S_AXI_WSTRB <= s;
		S_AXI_AWVALID <= 1'h1;
		S_AXI_WVALID <= 1'h1;
		S_AXI_BREADY <= 1'h1;
		do begin
			@(posedge REF_CLK);
			if (S_AXI_AWREADY) S_AXI_AWVALID <= 1'h0;
			if (S_AXI_WREADY) S_AXI_WVALID <= 1'h0;
		end while (S_AXI_BVALID !== 1'h1);
		S_AXI_BREADY <= 1'h0;
		chk({30'h0, S_AXI_BRESP}, {30'h0, r});
	endtask
	task automatic rd(input logic [7:0] i, d, input logic [1:0] r);
		@(posedge REF_CLK);
		S_AXI_ARADDR <= {i, 2'h0};
		S_AXI_ARVALID <= 1'h1;
		S_AXI_RREADY <= 1'h1;
		do begin
			@(posedge REF_CLK);
			if (S_AXI_ARREADY) S_AXI_ARVALID <= 1'h0;
		end while (S_AXI_RVALID !== 1'h1);
		S_AXI_RREADY <= 1'h0;
		chk(S_AXI_RDATA, {24'h0, d});
		chk({30'h0, S_AXI_RRESP}, {30'h0, r});
	endtask
	// Synchronisers add latency, so settle four edges
	task automatic pth(input logic t, s, l, eo, ea);
		@(posedge REF_CLK);
		TIMESTAMP_OUTPUT_ENABLE <= t;
		SYSREF_IN <= s;
		SAMPLE_LSB_IN <= l;
		repeat (4) @(posedge REF_CLK);
		#1;
		chk({30'h0, SAMPLE_LSB_OUT, SYSREF_ALIGN}, {30'h0, eo, ea});
	endtask
	task automatic test_done;
		if (failures == 0 && compares > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	initial begin
		#100000;
		failures++;
		test_done;
	end
	initial begin
		repeat (4) @(posedge REF_CLK);
		RST_B <= 1'h1;
		foreach (rows[k]) begin
			wr(rows[k].i, rows[k].w, 4'h1, rows[k].b);
			rd(rows[k].i, rows[k].r, rows[k].q);
		end
		chk({15'h0, INPUT_A_FULLSCALE_CODE, INPUT_A_FULLSCALE_LOW}, 32'h00002469);
		chk({15'h0, INPUT_B_FULLSCALE_CODE, INPUT_B_FULLSCALE_LOW}, 32'h0001FFFE);
		chk({27'h0, SYSREF_WINDOW_ZOOM, SYSREF_DELAY_SELECT}, 32'h00000015);
		chk({30'h0, DEVICE_CLOCK_DC_COUPLED_ENABLE, SYSREF_DC_COUPLED_ENABLE},
			32'h00000003);
		pth(1'h1, 1'h1, 1'h0, 1'h1, 1'h0);
		pth(1'h0, 1'h1, 1'h0, 1'h0, 1'h0);
		pth(1'h1, 1'h0, 1'h1, 1'h0, 1'h1);
		wr(8'h2A, 8'h00, 4'h1, OK);
		pth(1'h1, 1'h1, 1'h0, 1'h0, 1'h1);
		// Delay select back to zero, as auto calibration needs
		wr(8'h29, 8'h00, 4'h1, OK);
		chk({27'h0, SYSREF_WINDOW_ZOOM, SYSREF_DELAY_SELECT}, 32'h00000000);
		@(posedge REF_CLK);
		RST_B <= 1'h0;
		repeat (2) @(posedge REF_CLK);
		RST_B <= 1'h1;
		rd(8'h31, 8'hA0, OK);
		rd(8'h3B, 8'h00, OK);
		wr(8'h38, 8'h01, 4'h0, OK);
		rd(8'h38, 8'h00, OK);
		// Code exactly at the recommended minimum is not flagged low
		wr(8'h32, 8'h00, 4'h1, OK);
		wr(8'h33, 8'h20, 4'h1, OK);
		chk({15'h0, INPUT_B_FULLSCALE_CODE, INPUT_B_FULLSCALE_LOW}, 32'h00004000);
		test_done;
	end
endmodule
